// >>> wdt_top.sv
// 15-bit watchdog with reload/prescale, start, refresh-arm and reset-status bits on the SFR port.
// Assumes the core issues one-cycle SFR read and write strobes; srst is the external reset.
`timescale 1ns/1ps

// Contract
// [R1] Watchdog is a 15-bit up-counter of high and low byte.
// [R2] Count at machine rate /2, or /128 when prescaler bit 7 set.
// [R3] On start, high byte loads from reload bits 6..0.
// [R4] External reset clears the whole reload register to zero.
// [R5] Reload field writable any time, running or stopped.
// [R6] Setting start bit 6 starts the counter.
// [R7] While stopped, reload write updates high byte immediately.
// [R8] While stopped, low byte stays zero.
// [R9] Running watchdog cannot be stopped by software; only refreshed.
// [R10] Refresh: set arm bit, next instruction set start bit; only then reload.
// [R11] Arm bit clears itself in the third machine cycle after set.
// [R12] Internal watchdog reset entered at counter state 7FFC.
// [R13] Internal reset length depends on prescaler selection.
// [R14] Watchdog reset keeps watchdog running and sets reset-status flag.
// [R15] Software can clear the reset-status flag by writing it.
// [R16] Refresh and watchdog reset clear low byte and prescaler, reload high.
module wdt_top
(
    input wire logic clock,
    input wire logic srst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    output logic wd_reset_out,
    output logic wd_running,
    output logic [14:0] wd_count
);

    wdt_pkg::wdt_state_t state_r;
    wdt_pkg::wdt_state_t state_nxt;
    logic [7:0] wd_reload_reg_r;
    logic [7:0] wd_reload_reg_nxt;
    logic [6:0] wd_count_high_r;
    logic [6:0] wd_count_high_nxt;
    logic [7:0] wd_count_low_r;
    logic [7:0] wd_count_low_nxt;
    logic wd_refresh_arm_r;
    logic wd_refresh_arm_nxt;
    logic [1:0] arm_age_r;
    logic [1:0] arm_age_nxt;
    logic wd_reset_status_r;
    logic wd_reset_status_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic mc_tick;
    logic cnt_tick;
    logic pre_clear;
    logic wr_reload;
    logic wr_arm;
    logic wr_start;
    logic wr_status;
    logic refresh;
    logic [14:0] count_now;
    logic [14:0] count_inc;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        hit = (addr == target);
    endfunction : hit

    // ------------------------------------------------------------
    // Rate generation
    // ------------------------------------------------------------
    wdt_tick_gen u_tick
    (
        .clock(clock),
        .srst(srst),
        .pre_clear(pre_clear),
        .slow(wd_reload_reg_r[wdt_pkg::WDT_PRESCALE_BIT]), // [R2]
        .mc_tick(mc_tick),
        .cnt_tick(cnt_tick)
    );

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    always_comb
    begin
        wr_reload = sfr_wr && hit(sfr_addr, wdt_pkg::WDT_ADDR_RELOAD);
        wr_arm = sfr_wr && hit(sfr_addr, wdt_pkg::WDT_ADDR_INT_ENABLE);
        wr_start = sfr_wr && hit(sfr_addr, wdt_pkg::WDT_ADDR_START) && sfr_wdata[wdt_pkg::WDT_START_BIT];
        wr_status = sfr_wr && hit(sfr_addr, wdt_pkg::WDT_ADDR_INT_PRIORITY);
        // Start write counts as refresh only while the arm bit is still alive
        refresh = wr_start && wd_refresh_arm_r && (state_r != wdt_pkg::WDT_ST_STOPPED); // [R10]
        count_now = {wd_count_high_r, wd_count_low_r}; // [R1]
        count_inc = count_now + 15'h0001;
    end

    // ------------------------------------------------------------
    // Counter and state
    // ------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        wd_count_high_nxt = wd_count_high_r;
        wd_count_low_nxt = wd_count_low_r;
        pre_clear = 1'b0;
        wd_reset_status_nxt = wd_reset_status_r;
        wd_reload_reg_nxt = wr_reload ? sfr_wdata : wd_reload_reg_r; // [R5]
        if (wr_status && !sfr_wdata[wdt_pkg::WDT_STATUS_BIT])
        begin
            wd_reset_status_nxt = 1'b0; // [R15]
        end
        case (state_r)
            wdt_pkg::WDT_ST_STOPPED:
            begin
                pre_clear = 1'b1;
                wd_count_low_nxt = wdt_pkg::WDT_LOW_ZERO; // [R8]
                if (wr_reload)
                begin
                    wd_count_high_nxt = sfr_wdata[6:0]; // [R7]
                end
                if (wr_start)
                begin
                    state_nxt = wdt_pkg::WDT_ST_RUNNING; // [R6]
                    wd_count_high_nxt = wr_reload ? sfr_wdata[6:0] : wd_reload_reg_r[6:0]; // [R3]
                end
            end
            wdt_pkg::WDT_ST_RUNNING, wdt_pkg::WDT_ST_RESET:
            begin
                // No path back to stopped except external reset
                if (refresh && state_r == wdt_pkg::WDT_ST_RUNNING)
                begin
                    wd_count_high_nxt = wd_reload_reg_r[6:0]; // [R16]
                    wd_count_low_nxt = wdt_pkg::WDT_LOW_ZERO; // [R9]
                    pre_clear = 1'b1;
                end
                else if (cnt_tick)
                begin
                    if (count_now == wdt_pkg::WDT_LAST_STATE)
                    begin
                        // Reset spans 7FFC..7FFF at the chosen rate, so its length follows the prescaler
                        state_nxt = wdt_pkg::WDT_ST_RUNNING; // [R13]
                        wd_count_high_nxt = wd_reload_reg_r[6:0]; // [R16]
                        wd_count_low_nxt = wdt_pkg::WDT_LOW_ZERO;
                        pre_clear = 1'b1;
                    end
                    else
                    begin
                        wd_count_high_nxt = count_inc[14:8]; // [R2]
                        wd_count_low_nxt = count_inc[7:0];
                        if (count_inc == wdt_pkg::WDT_TRIP_STATE)
                        begin
                            state_nxt = wdt_pkg::WDT_ST_RESET; // [R12]
                            wd_reset_status_nxt = 1'b1; // [R14]
                        end
                    end
                end
            end
            default:
            begin
                state_nxt = wdt_pkg::WDT_ST_STOPPED;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Refresh arm
    // ------------------------------------------------------------
    always_comb
    begin
        wd_refresh_arm_nxt = wd_refresh_arm_r;
        arm_age_nxt = arm_age_r;
        if (wr_arm)
        begin
            wd_refresh_arm_nxt = sfr_wdata[wdt_pkg::WDT_ARM_BIT];
            arm_age_nxt = 2'h0;
        end
        else if (wd_refresh_arm_r && mc_tick)
        begin
            arm_age_nxt = arm_age_r + 2'h1;
            if (arm_age_nxt == wdt_pkg::WDT_ARM_LIFE)
            begin
                wd_refresh_arm_nxt = 1'b0; // [R11]
            end
        end
        // Internal reset clears the arm bit like any other core state
        if (state_r == wdt_pkg::WDT_ST_RESET)
        begin
            wd_refresh_arm_nxt = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_comb
    begin
        rdata_nxt = rdata_r;
        if (sfr_rd)
        begin
            rdata_nxt = wdt_pkg::WDT_READ_ZERO;
            if (hit(sfr_addr, wdt_pkg::WDT_ADDR_RELOAD))
            begin
                rdata_nxt = wd_reload_reg_r;
            end
            else if (hit(sfr_addr, wdt_pkg::WDT_ADDR_INT_ENABLE))
            begin
                rdata_nxt[wdt_pkg::WDT_ARM_BIT] = wd_refresh_arm_r;
            end
            else if (hit(sfr_addr, wdt_pkg::WDT_ADDR_INT_PRIORITY))
            begin
                rdata_nxt[wdt_pkg::WDT_STATUS_BIT] = wd_reset_status_r;
            end
            else if (hit(sfr_addr, wdt_pkg::WDT_ADDR_START))
            begin
                rdata_nxt[wdt_pkg::WDT_START_BIT] = (state_r != wdt_pkg::WDT_ST_STOPPED);
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state_r <= wdt_pkg::WDT_ST_STOPPED;
            wd_reload_reg_r <= wdt_pkg::WDT_RELOAD_RESET; // [R4]
            wd_count_high_r <= 7'h00;
            wd_count_low_r <= 8'h00;
            wd_refresh_arm_r <= 1'b0;
            arm_age_r <= 2'h0;
            wd_reset_status_r <= 1'b0;
            rdata_r <= 8'h00;
        end
        else
        begin
            state_r <= state_nxt;
            wd_reload_reg_r <= wd_reload_reg_nxt;
            wd_count_high_r <= wd_count_high_nxt;
            wd_count_low_r <= wd_count_low_nxt;
            wd_refresh_arm_r <= wd_refresh_arm_nxt;
            arm_age_r <= arm_age_nxt;
            wd_reset_status_r <= wd_reset_status_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign sfr_rdata = rdata_r;
    assign wd_reset_out = (state_r == wdt_pkg::WDT_ST_RESET); // [R14]
    assign wd_running = (state_r != wdt_pkg::WDT_ST_STOPPED);
    assign wd_count = count_now;

endmodule : wdt_top

// >>> wdt_pkg.sv
// Constants for the 15-bit watchdog: register addresses, bit positions, reset values, rates.
// Assumes an 8-bit special function register port inside the controller core.
package wdt_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] WDT_ADDR_RELOAD = 8'h86;
    localparam logic [7:0] WDT_ADDR_INT_ENABLE = 8'hA8;
    localparam logic [7:0] WDT_ADDR_INT_PRIORITY = 8'hA9;
    localparam logic [7:0] WDT_ADDR_START = 8'hB8;

    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int WDT_PRESCALE_BIT = 7;
    localparam int WDT_START_BIT = 6;
    localparam int WDT_ARM_BIT = 6;
    localparam int WDT_STATUS_BIT = 6;
    localparam logic [7:0] WDT_RELOAD_RESET = 8'h00;
    localparam logic [7:0] WDT_LOW_ZERO = 8'h00;
    localparam logic [7:0] WDT_READ_ZERO = 8'h00;

    // ------------------------------------------------------------
    // Counter and timing
    // ------------------------------------------------------------
    localparam int WDT_COUNT_W = 15;
    localparam logic [14:0] WDT_TRIP_STATE = 15'h7FFC;
    localparam logic [14:0] WDT_LAST_STATE = 15'h7FFF;
    localparam int WDT_CLKS_PER_MC = 12;
    localparam int WDT_DIV_FAST = 2;
    localparam int WDT_DIV_SLOW = 128;
    localparam logic [1:0] WDT_ARM_LIFE = 2'h3;

    typedef enum logic [1:0] {
        WDT_ST_STOPPED = 2'b00,
        WDT_ST_RUNNING = 2'b01,
        WDT_ST_RESET = 2'b11
    } wdt_state_t;

endpackage : wdt_pkg

// >>> wdt_tick_gen.sv
// Machine-cycle enable and watchdog count enable (machine rate divided by 2 or 128).
// Assumes one system clock; every slower rate leaves here as a one-cycle pulse.
`timescale 1ns/1ps

module wdt_tick_gen
(
    input wire logic clock,
    input wire logic srst,
    input wire logic pre_clear,
    input wire logic slow,
    output logic mc_tick,
    output logic cnt_tick
);

    logic [3:0] mc_cnt_r;
    logic [3:0] mc_cnt_nxt;
    logic [6:0] pre_cnt_r;
    logic [6:0] pre_cnt_nxt;
    logic [6:0] pre_last;

    // ------------------------------------------------------------
    // Dividers
    // ------------------------------------------------------------
    always_comb
    begin
        pre_last = slow ? 7'(wdt_pkg::WDT_DIV_SLOW - 1) : 7'(wdt_pkg::WDT_DIV_FAST - 1);
        mc_tick = (mc_cnt_r == 4'(wdt_pkg::WDT_CLKS_PER_MC - 1));
        cnt_tick = mc_tick && (pre_cnt_r >= pre_last);
        mc_cnt_nxt = mc_tick ? 4'h0 : mc_cnt_r + 4'h1;
        pre_cnt_nxt = pre_cnt_r;
        // Machine-cycle phase is kept; only the prescaler restarts on clear
        if (pre_clear)
        begin
            pre_cnt_nxt = 7'h00;
        end
        else if (cnt_tick)
        begin
            pre_cnt_nxt = 7'h00;
        end
        else if (mc_tick)
        begin
            pre_cnt_nxt = pre_cnt_r + 7'h01;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            mc_cnt_r <= 4'h0;
            pre_cnt_r <= 7'h00;
        end
        else
        begin
            mc_cnt_r <= mc_cnt_nxt;
            pre_cnt_r <= pre_cnt_nxt;
        end
    end

endmodule : wdt_tick_gen

// >>> wdt_checker.sv
// Concurrent checks on the watchdog counter, reset pulse and SFR read-back.
// Assumes it is bound to wdt_top and sees only that module's ports.
`timescale 1ns/1ps

module wdt_checker
(
    input wire logic clock,
    input wire logic srst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_rdata,
    input wire logic wd_reset_out,
    input wire logic wd_running,
    input wire logic [14:0] wd_count
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    logic [7:0] reload_r;
    logic [7:0] reload_nxt;
    logic [12:0] hold_r;
    logic [12:0] hold_nxt;
    logic [14:0] load_v;
    logic wr_arm;
    logic wr_go;
    assign load_v = {reload_r[6:0], 8'h00};
    assign wr_arm = sfr_wr && sfr_addr == wdt_pkg::WDT_ADDR_INT_ENABLE && sfr_wdata[6];
    assign wr_go = sfr_wr && sfr_addr == wdt_pkg::WDT_ADDR_START && sfr_wdata[6];

    // Shadow of the reload register; a watchdog reset must not clear it
    always_comb
    begin
        reload_nxt = (sfr_wr && sfr_addr == wdt_pkg::WDT_ADDR_RELOAD) ? sfr_wdata : reload_r;
        hold_nxt = wd_reset_out ? hold_r + 13'h0001 : 13'h0000;
        if (srst)
        begin
            reload_nxt = 8'h00;
            hold_nxt = 13'h0000;
        end
    end

    always_ff @(posedge clock)
    begin
        reload_r <= reload_nxt;
        hold_r <= hold_nxt;
    end

    reset_clear_a: assert property (disable iff (1'b0) srst |=> wd_count == 15'h0000 && !wd_running)
        else $error("outputs not cleared by reset");
    stopped_hold_a: assert property (!wd_running |-> wd_count == load_v)
        else $error("stopped counter differs from reload value");
    start_load_a: assert property (!wd_running && wr_go |=> wd_running && wd_count == load_v)
        else $error("start did not load counter");
    run_stays_a: assert property (wd_running |=> wd_running)
        else $error("running watchdog stopped");
    refresh_load_a: assert property (wr_arm ##1 (wr_go && wd_running && !wd_reset_out) |=> wd_count == load_v)
        else $error("refresh sequence did not reload");
    trip_count_a: assert property ($rose(wd_reset_out) |-> wd_count == 15'h7FFC && wd_running)
        else $error("watchdog reset at wrong count");
    pulse_len_a: assert property ($fell(wd_reset_out) && !$past(srst) |-> hold_r == (reload_r[7] ? 13'h1800 : 13'h0060))
        else $error("watchdog reset length wrong");
    count_step_a: assert property (wd_running && $past(wd_running) && !$past(sfr_wr)
        && !$past(wd_reset_out) && wd_count != $past(wd_count) |-> wd_count == 15'($past(wd_count) + 15'h0001))
        else $error("counter did not step by one");
    status_read_a: assert property (sfr_rd && sfr_addr == wdt_pkg::WDT_ADDR_INT_PRIORITY && wd_reset_out
        |=> sfr_rdata[6])
        else $error("status flag not set during watchdog reset");
    unmapped_read_a: assert property (sfr_rd && !(sfr_addr inside {8'h86, 8'hA8, 8'hA9, 8'hB8}) |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");

    cover property ($rose(wd_reset_out));
    cover property (wr_arm ##1 wr_go);
    cover property (!wd_running && wr_go);
endmodule : wdt_checker

// >>> wdt_tb.sv
// Self-checking bench for wdt_top: reset values, stopped loads, start, refresh, timeout, prescaler.
// Assumes a 125 MHz clock; the bench drives the SFR port itself with one-cycle strobes.
`timescale 1ns/1ps

module testbench;
    localparam logic [7:0] RL = wdt_pkg::WDT_ADDR_RELOAD;
    localparam logic [7:0] EN = wdt_pkg::WDT_ADDR_INT_ENABLE;
    localparam logic [7:0] PR = wdt_pkg::WDT_ADDR_INT_PRIORITY;
    localparam logic [7:0] ST = wdt_pkg::WDT_ADDR_START;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_rdata;
    logic wd_reset_out;
    logic wd_running;
    logic [14:0] wd_count;
    logic [7:0] rv;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n;

    wdt_top uut (.clock(clock), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
        .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .wd_reset_out(wd_reset_out), .wd_running(wd_running),
        .wd_count(wd_count));

    always #4 clock = ~clock;

    // Whole run needs about 9000 cycles; the ceiling leaves ample margin
    always @(posedge clock)
    begin
        cyc = cyc + 1;
        if (cyc == 40000)
        begin
            bad_count++;
            wrap_up();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            bad_count++;
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clock);
        sfr_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clock);
        sfr_rd <= 1'b0;
        #1;
        rv = sfr_rdata;
    endtask : rd

    // Arm and start on consecutive edges, as the refresh requires
    task automatic arm_go();
        @(posedge clock);
        sfr_addr <= EN;
        sfr_wdata <= 8'h40;
        sfr_wr <= 1'b1;
        @(posedge clock);
        sfr_addr <= ST;
        @(posedge clock);
        sfr_wr <= 1'b0;
        #1;
    endtask : arm_go

    task automatic wait_rst(input logic lvl, input int lim);
        while (wd_reset_out === lvl && n < lim)
        begin
            @(posedge clock);
            #1;
            n++;
        end
    endtask : wait_rst

    // First pass only syncs on a step: the span after a prescaler restart is shorter than a full period
    task automatic gap(input int lo, input int hi);
        logic [14:0] c;
        repeat (2)
        begin
            c = wd_count;
            n = 0;
            while (wd_count === c && n < 2000)
            begin
                @(posedge clock);
                #1;
                n++;
            end
        end
        chk(16'(n >= lo && n <= hi), 16'h0001);
    endtask : gap

    task automatic t_stopped();
        rd(RL);
        chk(16'(rv), 16'h0000);
        rd(8'h55);
        chk(16'(rv), 16'h0000);
        wr(RL, 8'h05);
        chk(16'(wd_count), 16'h0500);
        rd(RL);
        chk(16'(rv), 16'h0005);
        wr(EN, 8'h40);
        rd(EN);
        chk(16'(rv), 16'h0040);
        repeat (40) @(posedge clock);
        rd(EN);
        chk(16'(rv), 16'h0000);
        $display("stopped test done");
    endtask : t_stopped

    task automatic t_fast();
        wr(RL, 8'h7F);
        wr(ST, 8'h40);
        chk(16'(wd_running), 16'h0001);
        chk(16'(wd_count), 16'h7F00);
        gap(24, 24);
        wr(ST, 8'h00);
        chk(16'(wd_running), 16'h0001);
        repeat (60) @(posedge clock);
        arm_go();
        chk(16'(wd_count), 16'h7F00);
        wr(EN, 8'h40);
        repeat (40) @(posedge clock);
        wr(ST, 8'h40);
        chk(16'(wd_count != 15'h7F00), 16'h0001);
        wr(RL, 8'h7E);
        n = 0;
        wait_rst(1'b0, 7000);
        chk(16'(wd_count), 16'h7FFC);
        rd(PR);
        chk(16'(rv), 16'h0040);
        chk(16'(wd_running), 16'h0001);
        n = 2;
        wait_rst(1'b1, 200);
        chk(16'(n), 16'h0060);
        chk(16'(wd_count), 16'h7E00);
        wr(PR, 8'h00);
        rd(PR);
        chk(16'(rv), 16'h0000);
        $display("fast test done");
    endtask : t_fast

    task automatic t_slow();
        @(posedge clock);
        srst <= 1'b1;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        rd(RL);
        chk(16'(rv), 16'h0000);
        wr(RL, 8'hFF);
        chk(16'(wd_count), 16'h7F00);
        wr(ST, 8'h40);
        gap(1536, 1536);
        $display("slow test done");
    endtask : t_slow

    task automatic wrap_up();
        $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : wrap_up

    initial
    begin
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        t_stopped();
        t_fast();
        t_slow();
        wrap_up();
    end
endmodule : testbench

bind wdt_top wdt_checker u_chk (.clock(clock), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .wd_reset_out(wd_reset_out),
    .wd_running(wd_running), .wd_count(wd_count));
